// ===== design/tbc_pkg.sv
package tbc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] TBC_OFS_CTRL = 8'h00;
    localparam logic [7:0] TBC_OFS_IFSC = 8'h04;
    localparam logic [7:0] TBC_OFS_IFSD = 8'h08;
    localparam logic [7:0] TBC_OFS_STATUS = 8'h0c;

    localparam int TBC_CTRL_LSI_EN_POS = 0;
    localparam int TBC_CTRL_LSI_MAX_POS = 4;
    localparam logic [7:0] TBC_CTRL_RST = 8'h00;
    localparam logic [7:0] TBC_IFSC_RST = 8'h20;
    localparam logic [7:0] TBC_IFSD_RST = 8'h20;

    localparam int TBC_ST_NS_POS = 0;
    localparam int TBC_ST_NR_POS = 1;
    localparam int TBC_ST_MUTE_POS = 2;
    localparam int TBC_ST_RXCH_POS = 3;
    localparam int TBC_ST_TXCH_POS = 4;
    localparam int TBC_ST_TURN_POS = 5;
    localparam int TBC_ST_START_POS = 6;
    localparam int TBC_ST_ERRS_POS = 8;
    localparam int TBC_ST_LAST_POS = 12;

    // ------------------------------------------------------------
    // block encodings
    // ------------------------------------------------------------
    localparam int TBC_PCB_I_NS_POS = 6;
    localparam int TBC_PCB_I_MORE_POS = 5;
    localparam int TBC_PCB_R_NR_POS = 4;
    localparam int TBC_PCB_S_RESP_POS = 5;
    localparam logic [7:0] TBC_PCB_I_BASE = 8'h00;
    localparam logic [7:0] TBC_PCB_R_BASE = 8'h80;
    localparam logic [7:0] TBC_PCB_S_BASE = 8'hc0;
    localparam logic [3:0] TBC_R_OK = 4'h0;
    localparam logic [3:0] TBC_R_EDC = 4'h1;
    localparam logic [3:0] TBC_R_OTHER = 4'h2;
    localparam logic [4:0] TBC_S_RESYNCH = 5'h00;
    localparam logic [4:0] TBC_S_IFS = 5'h01;
    localparam logic [4:0] TBC_S_ABORT = 5'h02;
    localparam logic [4:0] TBC_S_WTX = 5'h03;
    localparam logic [7:0] TBC_LEN_RFU = 8'hff;
    localparam logic [3:0] TBC_LSI_GLOBAL = 4'h0;

    // invalid blocks answered in a row before the card falls silent
    localparam logic [3:0] TBC_MAX_RETX = 4'h3;

    typedef enum {TBC_LAST_NONE, TBC_LAST_I, TBC_LAST_R, TBC_LAST_SREQ, TBC_LAST_SRESP} tbc_last_t;

endpackage : tbc_pkg

// ===== design/tbc_block_layer.sv
// Operation
// - detect invalid blocks: parity/EDC, NAD, PCB, length, sync, missing S response
// - card retransmits, answers resynch request, otherwise goes silent
// - resynch request and response travel on logical interface 0
// - first received block invalid: card answers R(0)
// - after sending I-block, invalid reply draws R-block asking expected N(S)
// - after sending R-block, invalid reply repeats same R-block
// - after S request, reply not an S response repeats the request
// - after S response, invalid reply draws R-block, not repeated response
// - card IFS request repeated once; then card stays receiving
// - NAD invalid when LSI out of range, off-transfer, or nonzero global
// - more-data bit zero ends chain; one requires a following I-block
// - more-data I-block answered by R(next N(S)); chain continues
// - abort request answered by abort response; R-block may follow
// - abort blocks travel on the LSI of the aborted chain
// - card chain blocks never longer than IFSD
// - card rejects blocks longer than IFSC with R-block code 2
// - R-block low bits: 0 ok, 1 EDC/parity, 2 other
// - S-block bit b6 marks response; low five bits give type
//
// Strobed register access and the placing of the registers were left to the implementer.
module tbc_block_layer
    import tbc_pkg::*;
(
    input wire logic ref_clk_in, // 25 MHz
    input wire logic rst_in, // sync, active high
    input wire logic [7:0] addr_in, // register byte address
    input wire logic [31:0] wr_data_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [31:0] rd_data_out, // read data, cycle after rd_in
    input wire logic rx_valid_in, // received block header pulse
    input wire logic [7:0] rx_nad_in, // received nad
    input wire logic [7:0] rx_pcb_in, // received pcb
    input wire logic [7:0] rx_len_in, // received len
    input wire logic [7:0] rx_inf_in, // first inf byte
    input wire logic rx_edc_err_in, // parity or edc error
    input wire logic rx_sync_err_in, // framing lost
    input wire logic app_send_in, // start sending a response
    input wire logic [15:0] app_total_in, // response length in bytes
    input wire logic ifs_send_in, // offer new receive size
    input wire logic [7:0] ifs_val_in, // offered receive size
    input wire logic abort_send_in, // abort own transmit chain
    output logic tx_valid_out, // send block pulse
    output logic [7:0] tx_nad_out, // nad to send
    output logic [7:0] tx_pcb_out, // pcb to send
    output logic [7:0] tx_len_out, // len to send
    output logic [7:0] tx_inf_out, // inf byte of s-block
    output logic rx_deliver_out, // accepted i-block pulse
    output logic rx_more_out, // delivered block is chained
    output logic abort_out, // chain aborted pulse
    output logic ifs_fail_out, // ifs request gave up pulse
    output logic mute_out // card unresponsive
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] ifsc_reg, ifsc_next;
    logic [7:0] ifsd_reg, ifsd_next;
    logic [31:0] rd_data_reg;
    logic ns_reg, ns_next;
    logic nr_reg, nr_next;
    logic start_reg, start_next;
    logic mute_reg, mute_next;
    logic turn_reg, turn_next;
    logic rx_chain_reg, rx_chain_next;
    logic tx_chain_reg, tx_chain_next;
    logic retry_reg, retry_next;
    logic [3:0] errs_reg, errs_next;
    logic [3:0] lsi_reg, lsi_next;
    logic [15:0] remain_reg, remain_next;
    tbc_last_t last_reg, last_next;
    logic tx_valid_reg, tx_valid_next;
    logic [7:0] tx_nad_reg, tx_nad_next;
    logic [7:0] tx_pcb_reg, tx_pcb_next;
    logic [7:0] tx_len_reg, tx_len_next;
    logic [7:0] tx_inf_reg, tx_inf_next;
    logic deliver_reg, deliver_next;
    logic more_reg, more_next;
    logic abort_reg, abort_next;
    logic ifs_fail_reg, ifs_fail_next;

    // ------------------------------------------------------------
    // received block decode
    // ------------------------------------------------------------
    wire is_i = ~rx_pcb_in[7];
    wire is_r = rx_pcb_in[7:6] == 2'b10;
    wire is_s = rx_pcb_in[7:6] == 2'b11;
    wire i_ns = rx_pcb_in[TBC_PCB_I_NS_POS];
    wire i_more = rx_pcb_in[TBC_PCB_I_MORE_POS];
    wire r_nr = rx_pcb_in[TBC_PCB_R_NR_POS];
    wire s_resp = rx_pcb_in[TBC_PCB_S_RESP_POS];
    wire [4:0] s_code = rx_pcb_in[4:0];
    wire lsi_en = ctrl_reg[TBC_CTRL_LSI_EN_POS];
    wire [3:0] lsi_max = ctrl_reg[TBC_CTRL_LSI_MAX_POS +: 4];
    wire [3:0] rx_lsi = rx_nad_in[3:0];
    wire s_global = is_s & (s_code == TBC_S_RESYNCH | s_code == TBC_S_IFS);
    wire s_has_inf = s_code == TBC_S_IFS | s_code == TBC_S_WTX;
    wire in_transfer = rx_chain_reg | tx_chain_reg;
    wire nad_bad = lsi_en & ((rx_lsi > lsi_max)
        | (in_transfer & ~s_global & rx_lsi != lsi_reg)
        | (s_global & rx_lsi != TBC_LSI_GLOBAL));
    wire r_bad = is_r & (rx_pcb_in[5] | rx_pcb_in[3:0] > TBC_R_OTHER
        | rx_len_in != 8'h00);
    wire s_bad = is_s & (s_code > TBC_S_WTX
        | (~s_resp & s_code == TBC_S_WTX)
        | (s_has_inf ? rx_len_in != 8'h01 : rx_len_in != 8'h00));
    wire len_over = is_i & rx_len_in > ifsc_reg;
    wire chain_bad = rx_chain_reg & ~is_i
        & ~(is_s & ~s_resp & (s_code == TBC_S_ABORT | s_code == TBC_S_RESYNCH));
    wire sent_req = last_reg == TBC_LAST_SREQ;
    wire match_resp = is_s & s_resp & s_code == tx_pcb_reg[4:0];
    wire unsol_resp = is_s & s_resp & ~sent_req;
    wire rx_bad = rx_edc_err_in | rx_sync_err_in | rx_len_in == TBC_LEN_RFU | len_over
        | r_bad | s_bad | nad_bad | chain_bad | unsol_resp;
    wire resp_missing = sent_req & ~match_resp & ~(is_s & ~s_resp & s_code == TBC_S_RESYNCH);
    wire [3:0] err_code = rx_edc_err_in ? TBC_R_EDC : TBC_R_OTHER;
    wire resynch_req = ~rx_bad & is_s & ~s_resp & s_code == TBC_S_RESYNCH;

    // ------------------------------------------------------------
    // transmit chain sizing
    // ------------------------------------------------------------
    wire [15:0] ifsd_wide = {8'h00, ifsd_reg};
    wire new_more = app_total_in > ifsd_wide;
    wire [7:0] new_len = new_more ? ifsd_reg : app_total_in[7:0];
    wire [15:0] left = remain_reg - {8'h00, tx_len_reg};
    wire left_more = left > ifsd_wide;
    wire [7:0] left_len = left_more ? ifsd_reg : left[7:0];
    wire [7:0] chain_nad = {4'h0, lsi_reg};

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    wire wr_ctrl = wr_in & addr_in == TBC_OFS_CTRL;
    wire wr_ifsc = wr_in & addr_in == TBC_OFS_IFSC;
    wire [31:0] status_word = {16'h0000, 1'b0, 3'(last_reg), errs_reg, 1'b0, start_reg,
        turn_reg, tx_chain_reg, rx_chain_reg, mute_reg, nr_reg, ns_reg};
    wire [31:0] rd_mux = addr_in == TBC_OFS_CTRL ? {24'h000000, ctrl_reg}
        : addr_in == TBC_OFS_IFSC ? {24'h000000, ifsc_reg}
        : addr_in == TBC_OFS_IFSD ? {24'h000000, ifsd_reg}
        : addr_in == TBC_OFS_STATUS ? status_word : 32'h00000000;

    // ------------------------------------------------------------
    // block protocol
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_next = wr_ctrl ? wr_data_in[7:0] : ctrl_reg;
        ifsc_next = wr_ifsc ? wr_data_in[7:0] : ifsc_reg;
        ifsd_next = ifsd_reg;
        ns_next = ns_reg;
        nr_next = nr_reg;
        start_next = start_reg;
        mute_next = mute_reg;
        turn_next = turn_reg;
        rx_chain_next = rx_chain_reg;
        tx_chain_next = tx_chain_reg;
        retry_next = retry_reg;
        errs_next = errs_reg;
        lsi_next = lsi_reg;
        remain_next = remain_reg;
        last_next = last_reg;
        tx_valid_next = 1'b0;
        tx_nad_next = tx_nad_reg;
        tx_pcb_next = tx_pcb_reg;
        tx_len_next = tx_len_reg;
        tx_inf_next = tx_inf_reg;
        deliver_next = 1'b0;
        more_next = more_reg;
        abort_next = 1'b0;
        ifs_fail_next = 1'b0;
        if (rx_valid_in & (mute_reg ? resynch_req : 1'b0))
        begin
            // silent card wakes only on a resynch request
            mute_next = 1'b0;
        end
        if (rx_valid_in & (~mute_reg | resynch_req))
        begin
            turn_next = 1'b0;
            if (rx_bad | resp_missing)
            begin
                if (start_reg)
                begin
                    start_next = 1'b0;
                    tx_valid_next = 1'b1;
                    tx_nad_next = 8'h00;
                    tx_pcb_next = {TBC_PCB_R_BASE[7:4], err_code};
                    tx_len_next = 8'h00;
                    last_next = TBC_LAST_R;
                end
                else if (errs_reg >= TBC_MAX_RETX)
                begin
                    mute_next = 1'b1;
                end
                else
                begin
                    errs_next = errs_reg + 4'h1;
                    case (last_reg)
                        TBC_LAST_SREQ:
                        begin
                            if (tx_pcb_reg[4:0] == TBC_S_IFS & retry_reg)
                            begin
                                ifs_fail_next = 1'b1;
                                last_next = TBC_LAST_NONE;
                            end
                            else
                            begin
                                retry_next = 1'b1;
                                tx_valid_next = 1'b1;
                            end
                        end
                        TBC_LAST_R:
                        begin
                            tx_valid_next = 1'b1;
                        end
                        default:
                        begin
                            // after an I-block, an S response or no pending block: ask again
                            tx_valid_next = 1'b1;
                            tx_nad_next = tx_nad_reg;
                            tx_pcb_next = {TBC_PCB_R_BASE[7:5], nr_reg, err_code};
                            tx_len_next = 8'h00;
                            last_next = TBC_LAST_R;
                        end
                    endcase
                end
            end
            else
            begin
                errs_next = 4'h0;
                retry_next = 1'b0;
                start_next = 1'b0;
                if (is_i)
                begin
                    if (i_ns == nr_reg)
                    begin
                        nr_next = ~nr_reg;
                        deliver_next = 1'b1;
                        more_next = i_more;
                        lsi_next = rx_lsi;
                        tx_chain_next = 1'b0;
                        if (i_more)
                        begin
                            rx_chain_next = 1'b1;
                            tx_valid_next = 1'b1;
                            tx_nad_next = rx_nad_in;
                            tx_pcb_next = {TBC_PCB_R_BASE[7:5], ~nr_reg, TBC_R_OK};
                            tx_len_next = 8'h00;
                            last_next = TBC_LAST_R;
                        end
                        else
                        begin
                            rx_chain_next = 1'b0;
                            turn_next = 1'b1;
                            last_next = TBC_LAST_NONE;
                        end
                    end
                    else
                    begin
                        // repeated block: our last answer was lost
                        tx_valid_next = 1'b1;
                    end
                end
                else if (is_r)
                begin
                    if (tx_chain_reg & r_nr == ns_reg)
                    begin
                        remain_next = left;
                        tx_chain_next = left_more;
                        ns_next = ~ns_reg;
                        tx_valid_next = 1'b1;
                        tx_nad_next = chain_nad;
                        tx_pcb_next = {TBC_PCB_I_BASE[7], ns_reg, left_more, 5'h00};
                        tx_len_next = left_len;
                        last_next = TBC_LAST_I;
                    end
                    else if (sent_req | last_reg == TBC_LAST_NONE)
                    begin
                        turn_next = last_reg == TBC_LAST_NONE;
                    end
                    else
                    begin
                        tx_valid_next = 1'b1;
                    end
                end
                else if (~s_resp)
                begin
                    tx_valid_next = 1'b1;
                    tx_pcb_next = rx_pcb_in | (8'h01 << TBC_PCB_S_RESP_POS);
                    tx_len_next = rx_len_in;
                    tx_inf_next = rx_inf_in;
                    tx_nad_next = rx_nad_in;
                    last_next = TBC_LAST_SRESP;
                    case (s_code)
                        TBC_S_RESYNCH:
                        begin
                            ns_next = 1'b0;
                            nr_next = 1'b0;
                            rx_chain_next = 1'b0;
                            tx_chain_next = 1'b0;
                            tx_nad_next = 8'h00;
                        end
                        TBC_S_IFS:
                        begin
                            ifsd_next = rx_inf_in;
                            tx_nad_next = 8'h00;
                        end
                        TBC_S_ABORT:
                        begin
                            rx_chain_next = 1'b0;
                            tx_chain_next = 1'b0;
                            abort_next = 1'b1;
                            tx_nad_next = chain_nad;
                        end
                        default:
                        begin
                            tx_valid_next = 1'b0;
                        end
                    endcase
                end
                else
                begin
                    // matching response to our own request
                    last_next = TBC_LAST_NONE;
                    turn_next = 1'b1;
                    if (s_code == TBC_S_IFS)
                    begin
                        ifsc_next = tx_inf_reg;
                    end
                    if (s_code == TBC_S_ABORT)
                    begin
                        abort_next = 1'b1;
                        tx_chain_next = 1'b0;
                        turn_next = 1'b0;
                        tx_valid_next = 1'b1;
                        tx_nad_next = chain_nad;
                        tx_pcb_next = {TBC_PCB_R_BASE[7:5], nr_reg, TBC_R_OK};
                        tx_len_next = 8'h00;
                        last_next = TBC_LAST_R;
                    end
                end
            end
        end
        else if (turn_reg & ~mute_reg & ~rx_valid_in)
        begin
            if (app_send_in)
            begin
                turn_next = 1'b0;
                remain_next = app_total_in;
                tx_chain_next = new_more;
                ns_next = ~ns_reg;
                tx_valid_next = 1'b1;
                tx_nad_next = chain_nad;
                tx_pcb_next = {TBC_PCB_I_BASE[7], ns_reg, new_more, 5'h00};
                tx_len_next = new_len;
                last_next = TBC_LAST_I;
            end
            else if (ifs_send_in | abort_send_in)
            begin
                turn_next = 1'b0;
                retry_next = 1'b0;
                tx_valid_next = 1'b1;
                tx_nad_next = ifs_send_in ? 8'h00 : chain_nad;
                tx_pcb_next = {TBC_PCB_S_BASE[7:5], ifs_send_in ? TBC_S_IFS : TBC_S_ABORT};
                tx_len_next = ifs_send_in ? 8'h01 : 8'h00;
                tx_inf_next = ifs_val_in;
                last_next = TBC_LAST_SREQ;
            end
        end
    end

    // ------------------------------------------------------------
    // flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            ctrl_reg <= TBC_CTRL_RST;
            ifsc_reg <= TBC_IFSC_RST;
            ifsd_reg <= TBC_IFSD_RST;
            rd_data_reg <= 32'h00000000;
            {ns_reg, nr_reg, mute_reg, turn_reg, rx_chain_reg, tx_chain_reg} <= 6'h00;
            start_reg <= 1'b1;
            retry_reg <= 1'b0;
            errs_reg <= 4'h0;
            lsi_reg <= 4'h0;
            remain_reg <= 16'h0000;
            last_reg <= TBC_LAST_NONE;
            {tx_valid_reg, deliver_reg, more_reg, abort_reg, ifs_fail_reg} <= 5'h00;
            {tx_nad_reg, tx_pcb_reg, tx_len_reg, tx_inf_reg} <= 32'h00000000;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            ifsc_reg <= ifsc_next;
            ifsd_reg <= ifsd_next;
            rd_data_reg <= rd_in ? rd_mux : 32'h00000000;
            {ns_reg, nr_reg, mute_reg, turn_reg} <= {ns_next, nr_next, mute_next, turn_next};
            {rx_chain_reg, tx_chain_reg} <= {rx_chain_next, tx_chain_next};
            start_reg <= start_next;
            retry_reg <= retry_next;
            errs_reg <= errs_next;
            lsi_reg <= lsi_next;
            remain_reg <= remain_next;
            last_reg <= last_next;
            {tx_valid_reg, deliver_reg, more_reg} <= {tx_valid_next, deliver_next, more_next};
            {abort_reg, ifs_fail_reg} <= {abort_next, ifs_fail_next};
            {tx_nad_reg, tx_pcb_reg} <= {tx_nad_next, tx_pcb_next};
            {tx_len_reg, tx_inf_reg} <= {tx_len_next, tx_inf_next};
        end
    end

    assign rd_data_out = rd_data_reg;
    assign tx_valid_out = tx_valid_reg;
    assign tx_nad_out = tx_nad_reg;
    assign tx_pcb_out = tx_pcb_reg;
    assign tx_len_out = tx_len_reg;
    assign tx_inf_out = tx_inf_reg;
    assign rx_deliver_out = deliver_reg;
    assign rx_more_out = more_reg;
    assign abort_out = abort_reg;
    assign ifs_fail_out = ifs_fail_reg;
    assign mute_out = mute_reg;

endmodule : tbc_block_layer

// ===== bench/tbc_asserts.sv
module tbc_check_asserts
    import tbc_pkg::*;
(
    input wire logic ref_clk_in, rst_in, rx_valid_in, rx_edc_err_in, rx_sync_err_in,
    input wire logic [7:0] rx_nad_in, rx_pcb_in, rx_len_in, rx_inf_in,
    input wire logic [7:0] tx_nad_out, tx_pcb_out, tx_inf_out,
    input wire logic tx_valid_out, rx_deliver_out, rx_more_out, abort_out,
    input wire logic ifs_fail_out, mute_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    wire logic rx_good = rx_valid_in && !rx_edc_err_in && !rx_sync_err_in && rx_nad_in == 8'h00;
    edc_reply_a: assert property (
        rx_valid_in && rx_edc_err_in && !mute_out |=> tx_valid_out || ifs_fail_out || mute_out)
        else $error("bad block left unanswered");
    r_code_a: assert property (
        tx_valid_out && tx_pcb_out[7:6] == 2'b10 |-> !tx_pcb_out[5] && tx_pcb_out[3:0] <= 4'h2)
        else $error("r-block code out of range");
    more_ack_a: assert property (
        rx_deliver_out && rx_more_out |-> tx_valid_out && tx_pcb_out[7:6] == 2'b10)
        else $error("chained block not acked");
    resynch_ans_a: assert property (
        rx_good && rx_pcb_in == 8'hc0 && rx_len_in == 8'h00
        |=> tx_valid_out && tx_pcb_out == 8'he0 && tx_nad_out == 8'h00) else $error("no resynch");
    ifs_echo_a: assert property (
        rx_good && rx_pcb_in == 8'hc1 && rx_len_in == 8'h01 && !mute_out && !rx_more_out
        && tx_pcb_out[7:5] != 3'b110
        |=> tx_pcb_out == 8'he1 && tx_inf_out == $past(rx_inf_in)) else $error("ifs echo wrong");
    abort_ans_a: assert property (
        rx_good && rx_pcb_in == 8'hc2 && rx_len_in == 8'h00 && !mute_out
        && tx_pcb_out[7:5] != 3'b110
        |=> abort_out && tx_valid_out && tx_pcb_out == 8'he2) else $error("abort unanswered");
    mute_quiet_a: assert property (
        mute_out && rx_valid_in && rx_pcb_in != 8'hc0 |=> !tx_valid_out) else $error("mute sent");
    mute_cause_a: assert property (
        $rose(mute_out) |-> $past(rx_valid_in)) else $error("mute without block");
    ifs_quit_a: assert property (
        ifs_fail_out |-> $past(rx_valid_in) && !tx_valid_out) else $error("ifs gave up wrongly");
endmodule : tbc_check_asserts

bind tbc_block_layer tbc_check_asserts u_tbc_check_asserts (.*);

// ===== bench/tbc_term_model.sv
module tbc_term_model (
    input wire logic ref_clk_in, // session clock
    output logic v_out, // block header strobe
    output logic [31:0] h_out, // nad, pcb, len, inf
    output logic edc_out // parity or edc error
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        v_out = 1'b0;
        h_out = 32'h0;
        edc_out = 1'b0;
    end
    // one header, then released lines show the inverse
    task automatic blk(input logic [31:0] h, input logic e);
        @(posedge ref_clk_in);
        v_out <= 1'b1;
        h_out <= h;
        edc_out <= e;
        @(posedge ref_clk_in);
        v_out <= 1'b0;
        h_out <= ~h;
        edc_out <= ~e;
    endtask : blk
endmodule : tbc_term_model

// ===== bench/tbc_block_layer_test.sv
module tbc_block_layer_test
    import tbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic k; logic [31:0] h; logic e; logic [17:0] x;} tbc_row_t;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, app = 1'b0, ifs = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic abt = 1'b0;
    logic [31:0] wd = 32'h0, h, rd_data_out;
    logic v, edc, tx_valid_out, rx_deliver_out, rx_more_out, abort_out, ifs_fail_out, mute_out;
    logic [7:0] tx_nad_out, tx_pcb_out, tx_len_out, tx_inf_out;
    int n_errors = 0, cmp_count = 0;
    // {kind, header, edc} -> {tx valid, abort, pcb, len}
    // terminal side: start-up retry, chain blocks at IFSC, IFS after over-IFSC reject
    tbc_row_t rows [12] = '{'{1'h0, 32'h00202000, 1'h1, 18'h28100}, '{1'h0, 32'h00202000,
        1'h0, 18'h29000}, '{1'h0, 32'h00400500, 1'h0, 18'h09000}, '{1'h1, 32'h0, 1'h0,
        18'h22020}, '{1'h0, 32'h00900000, 1'h0, 18'h24010}, '{1'h0, 32'h00002100, 1'h0,
        18'h28200}, '{1'h0, 32'h00002100, 1'h1, 18'h28200}, '{1'h0, 32'h00c10140, 1'h0,
        18'h2e101}, '{1'h0, 32'h00c10140, 1'h1, 18'h28100}, '{1'h0, 32'h00c00000, 1'h0,
        18'h2e000}, '{1'h0, 32'h00202000, 1'h0, 18'h29000}, '{1'h0, 32'h00c20000, 1'h0,
        18'h3e200}};
    always #20 ref_clk_in = ~ref_clk_in;
    tbc_block_layer u_tbc_block_layer (.ref_clk_in, .rst_in, .addr_in, .wr_data_in(wd),
        .wr_in, .rd_in, .rd_data_out, .rx_valid_in(v), .rx_nad_in(h[31:24]),
        .rx_pcb_in(h[23:16]), .rx_len_in(h[15:8]), .rx_inf_in(h[7:0]), .rx_edc_err_in(edc),
        .rx_sync_err_in(1'b0), .app_send_in(app), .app_total_in(16'h0030), .ifs_send_in(ifs),
        .ifs_val_in(8'h40), .abort_send_in(abt), .tx_valid_out, .tx_nad_out, .tx_pcb_out,
        .tx_len_out, .tx_inf_out, .rx_deliver_out, .rx_more_out, .abort_out, .ifs_fail_out,
        .mute_out);
    tbc_term_model u_tbc_term_model (.ref_clk_in, .v_out(v), .h_out(h), .edc_out(edc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic blk(input logic [31:0] hd, input logic e);
        u_tbc_term_model.blk(hd, e);
        #1;
    endtask : blk
    // s = {app send, ifs send, abort send, write, read}, one cycle
    task automatic go(input logic [4:0] s, input logic [7:0] ad, input logic [31:0] d);
        @(posedge ref_clk_in);
        {app, ifs, abt, wr_in, rd_in} <= s;
        addr_in <= ad;
        wd <= d;
        @(posedge ref_clk_in);
        {app, ifs, abt, wr_in, rd_in} <= 5'h00;
        #1;
    endtask : go
    task automatic end_of_test();
        $display("%0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial
    begin
        #20000;
        n_errors++;
        end_of_test();
    end
    initial
    begin
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        // ----------------------------------------
        // block exchange table
        // ----------------------------------------
        foreach (rows[i])
        begin
            if (rows[i].k)
                go(5'h10, 8'h00, 32'h0);
            else
                blk(rows[i].h, rows[i].e);
            chk({tx_valid_out, abort_out, tx_pcb_out, tx_len_out}, rows[i].x);
        end
        $display("table done");
        blk(32'h00c00000, 1'b0);
        blk(32'h00000100, 1'b0);
        chk(rx_deliver_out, 1'b1);
        go(5'h08, 8'h00, 32'h0);
        chk({tx_valid_out, tx_pcb_out, tx_inf_out}, 17'h1c140);
        blk(32'h0, 1'b1);
        chk({tx_valid_out, tx_pcb_out}, 9'h1c1);
        blk(32'h0, 1'b1);
        chk({tx_valid_out, ifs_fail_out}, 2'h1);
        $display("ifs retry done");
        blk(32'h00800000, 1'b0);
        chk({tx_valid_out, ifs_fail_out}, 2'h0);
        blk(32'h00c00000, 1'b0);
        repeat (3)
        begin
            blk(32'h0, 1'b1);
            chk(tx_valid_out, 1'b1);
        end
        blk(32'h0, 1'b1);
        chk(mute_out, 1'b1);
        blk(32'h00000100, 1'b0);
        chk(tx_valid_out, 1'b0);
        blk(32'h00c00000, 1'b0);
        chk({tx_valid_out, tx_pcb_out}, 9'h1e0);
        $display("mute done");
        blk(32'h00000100, 1'b0);
        go(5'h04, 8'h00, 32'h0);
        chk({tx_valid_out, tx_pcb_out}, 9'h1c2);
        blk(32'h00e20000, 1'b0);
        chk({tx_valid_out, abort_out, tx_pcb_out}, 10'h390);
        $display("abort done");
        go(5'h01, TBC_OFS_IFSC, 32'h0);
        chk(rd_data_out, 32'h20);
        go(5'h02, TBC_OFS_IFSC, 32'h10);
        go(5'h01, TBC_OFS_IFSC, 32'h0);
        chk(rd_data_out, 32'h10);
        go(5'h01, 8'hf0, 32'h0);
        chk(rd_data_out, 32'h0);
        go(5'h02, TBC_OFS_CTRL, 32'h11);
        blk(32'h02000100, 1'b0);
        chk({tx_valid_out, rx_deliver_out, tx_pcb_out}, 10'h290);
        $display("registers done");
        end_of_test();
    end
endmodule : tbc_block_layer_test
